// *** logic/gpio_port.sv ***
/*
 gpio_port: three 8-bit ports with output latches, pin reads, read-modify-
 write latch reads, per-port drive select and a two-port pattern match.
 assumes: the cpu core presents sfr accesses on one clock; bit accesses
 arrive as bit_wr with a bit index; rmw_rd is asserted by the core for
 read-modify-write instructions; pins are asynchronous to clk.
*/
// Contract
// - one drive select bit per port sets high or low drive for all its pins.
// - after reset every port's drive select shows high drive.
// - each matching port has a software written expected value register.
// - mismatch fires when masked pins differ from masked expected values.
// - matching sees the real pin levels whatever the crossbar does.
// - the mismatch event serves both as interrupt request and idle wake.
// - port registers are reachable as whole bytes and as single bits.
// - a port write lands in an output latch that keeps driving the pins.
// - an ordinary port read returns the pin levels, not the latch.
// - a read-modify-write access reads the latch instead of the pins.
// - the latch read applies to every read-modify-write instruction kind.
// - expected bit 0 compares low, 1 compares high; resets to all ones.
// - port one width is a build parameter of 8, 7 or 4 pins.
`timescale 1ns/1ns
module gpio_port #(
   parameter int P1_WIDTH = 8
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic        bit_wr,
   input  wire logic [2:0]  bit_idx,
   input  wire logic        bit_val,
   input  wire logic        rmw_rd,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   input  wire logic [7:0]  pin_in0,
   input  wire logic [7:0]  pin_in1,
   input  wire logic [7:0]  pin_in2,
   output logic      [7:0]  pin_out0,
   output logic      [7:0]  pin_out1,
   output logic      [7:0]  pin_out2,
   output logic      [2:0]  port_drive_select,
   output logic             mismatch_irq,
   output logic             mismatch_wake
);
   // port one bits above the built width have no pin and never match
   localparam logic [7:0] P1_IMPL =
      8'((9'h001 << P1_WIDTH) - 9'h001);

   logic [7:0] sync1_reg [gpio_pkg::NUM_PORTS];
   logic [7:0] sync2_reg [gpio_pkg::NUM_PORTS];
   logic [7:0] latch_reg [gpio_pkg::NUM_PORTS];
   logic [7:0] port0_exp_reg;
   logic [7:0] port0_mask_reg;
   logic [7:0] port_one_expected_value_reg;
   logic [7:0] port_one_compare_mask_reg;
   logic [2:0] drive_reg;
   logic [7:0] pin_raw [gpio_pkg::NUM_PORTS];
   logic       mismatch_next;
   logic [7:0] rdata_next;

   // returns the port index hit by an address, or NUM_PORTS for none
   function automatic int port_of(input logic [7:0] a);
      if (a == gpio_pkg::PORT0_ADDR)
         return 0;
      else if (a == gpio_pkg::PORT1_ADDR)
         return 1;
      else if (a == gpio_pkg::PORT2_ADDR)
         return 2;
      else
         return gpio_pkg::NUM_PORTS;
   endfunction

   // single bit update of a byte, used by bit writes
   function automatic logic [7:0] set_bit(input logic [7:0] v,
                                          input logic [2:0] i,
                                          input logic       b);
      logic [7:0] r;
      r = v;
      r[i] = b;
      return r;
   endfunction

   // true when any pin under the mask sits away from its expected level
   function automatic logic masked_differs(input logic [7:0] pins,
                                           input logic [7:0] exp_v,
                                           input logic [7:0] mask);
      return (pins & mask) != (exp_v & mask);
   endfunction

   assign pin_raw[0] = pin_in0;
   assign pin_raw[1] = pin_in1;
   assign pin_raw[2] = pin_in2;

   genvar g;
   generate
      // one synchroniser and one latch per port
      for (g = 0; g < gpio_pkg::NUM_PORTS; g++) begin : g_port
         // pin reads of a port show zero until two edges after reset, while
         // the synchroniser fills; every flop stays resettable that way
         always_ff @(posedge clk) begin
            if (!resetn) begin
               sync1_reg[g] <= gpio_pkg::ZERO_BYTE;
               sync2_reg[g] <= gpio_pkg::ZERO_BYTE;
            end else begin
               sync1_reg[g] <= pin_raw[g];
               sync2_reg[g] <= sync1_reg[g];
            end
         end

         always_ff @(posedge clk) begin
            if (!resetn)
               latch_reg[g] <= gpio_pkg::LATCH_RESET;
            // a byte write beats a bit write arriving in the same cycle
            else if (sfr_wr && port_of(sfr_addr) == g)
               latch_reg[g] <= sfr_wdata;
            else if (bit_wr && port_of(sfr_addr) == g)
               // bit writes modify the latch, never the pins
               latch_reg[g] <= set_bit(latch_reg[g], bit_idx, bit_val);
         end
      end
   endgenerate

   // the latch holds its value until the next write, so pins follow it
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pin_out0 <= gpio_pkg::LATCH_RESET;
         pin_out1 <= gpio_pkg::LATCH_RESET;
         pin_out2 <= gpio_pkg::LATCH_RESET;
      end else begin
         pin_out0 <= latch_reg[0];
         pin_out1 <= latch_reg[1];
         pin_out2 <= latch_reg[2];
      end
   end

   // expected values reset to all ones and masks to zero, so no event
   // can fire until software arms a mask
   always_ff @(posedge clk) begin
      if (!resetn) begin
         port0_exp_reg               <= gpio_pkg::EXP_RESET;
         port0_mask_reg              <= gpio_pkg::MASK_RESET;
         port_one_expected_value_reg <= gpio_pkg::EXP_RESET;
         port_one_compare_mask_reg   <= gpio_pkg::MASK_RESET;
      end else if (sfr_wr) begin
         case (sfr_addr)
            gpio_pkg::PORT0_EXP_ADDR:  port0_exp_reg <= sfr_wdata;
            gpio_pkg::PORT0_MASK_ADDR: port0_mask_reg <= sfr_wdata;
            gpio_pkg::PORT1_EXP_ADDR:
               port_one_expected_value_reg <= sfr_wdata;
            gpio_pkg::PORT1_MASK_ADDR:
               port_one_compare_mask_reg <= sfr_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn)
         drive_reg <= gpio_pkg::DRIVE_RESET;
      else if (sfr_wr && sfr_addr == gpio_pkg::DRIVE_SEL_ADDR)
         drive_reg <= sfr_wdata[2:0];
   end

   // drive select passes one extra flop so it moves with the pin latches
   always_ff @(posedge clk) begin
      if (!resetn)
         port_drive_select <= gpio_pkg::DRIVE_RESET;
      else
         port_drive_select <= drive_reg;
   end

   // compares synchronised pins, so crossbar routing does not hide them;
   // port one drops the bits that have no pin in this build
   always_comb begin
      mismatch_next =
         masked_differs(sync2_reg[0], port0_exp_reg,
                        port0_mask_reg) ||
         masked_differs(sync2_reg[1],
                        port_one_expected_value_reg,
                        port_one_compare_mask_reg & P1_IMPL);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mismatch_irq  <= 1'h0;
         mismatch_wake <= 1'h0;
      end else begin
         mismatch_irq  <= mismatch_next;
         mismatch_wake <= mismatch_next;
      end
   end

   // a read-modify-write read returns the latch, so a bit update never
   // copies the outside level of an input pin into its output
   always_comb begin
      rdata_next = gpio_pkg::ZERO_BYTE;
      if (port_of(sfr_addr) != gpio_pkg::NUM_PORTS)
         rdata_next = rmw_rd ? latch_reg[port_of(sfr_addr)]
                             : sync2_reg[port_of(sfr_addr)];
      else
         case (sfr_addr)
            gpio_pkg::PORT0_EXP_ADDR:  rdata_next = port0_exp_reg;
            gpio_pkg::PORT0_MASK_ADDR: rdata_next = port0_mask_reg;
            gpio_pkg::PORT1_EXP_ADDR:
               rdata_next = port_one_expected_value_reg;
            gpio_pkg::PORT1_MASK_ADDR:
               rdata_next = port_one_compare_mask_reg;
            gpio_pkg::DRIVE_SEL_ADDR:  rdata_next = {5'h00, drive_reg};
            default:                   rdata_next = gpio_pkg::ZERO_BYTE;
         endcase
   end

   // read data is registered; it follows the address one cycle later
   always_ff @(posedge clk) begin
      if (!resetn)
         sfr_rdata <= gpio_pkg::ZERO_BYTE;
      else if (sfr_rd || rmw_rd)
         sfr_rdata <= rdata_next;
   end
endmodule // gpio_port

// *** pkg/gpio_pkg.sv ***
/*
 gpio_pkg: register addresses, reset values and widths for the general
 purpose port block with pattern match.
 assumes: an 8-bit special function register bus driven by the cpu core.
*/
package gpio_pkg;
   localparam int          ADDR_W           = 8;
   localparam int          DATA_W           = 8;
   localparam int          NUM_PORTS        = 3;
   // port latch registers, bit addressable
   localparam logic [7:0]  PORT0_ADDR       = 8'h80;
   localparam logic [7:0]  PORT1_ADDR       = 8'h90;
   localparam logic [7:0]  PORT2_ADDR       = 8'ha0;
   localparam logic [7:0]  PORT0_EXP_ADDR   = 8'hfc;
   localparam logic [7:0]  PORT0_MASK_ADDR  = 8'hfd;
   localparam logic [7:0]  PORT1_EXP_ADDR   = 8'hed;
   localparam logic [7:0]  PORT1_MASK_ADDR  = 8'hee;
   localparam logic [7:0]  DRIVE_SEL_ADDR   = 8'hf6;
   localparam logic [7:0]  LATCH_RESET      = 8'hff;
   localparam logic [7:0]  EXP_RESET        = 8'hff;
   localparam logic [7:0]  MASK_RESET       = 8'h00;
   // one bit per port, 1 selects high drive
   localparam logic [2:0]  DRIVE_RESET      = 3'h7;
   localparam logic [7:0]  ZERO_BYTE        = 8'h00;
endpackage

// *** verification/gpio_port_asserts.sv ***
/* gpio_port_asserts: port timing checks of the port block.
   assumes: bound to gpio_port, whose port names it reuses. */
`timescale 1ns/1ns
module gpio_port_asserts (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic       bit_wr,
   input wire logic [2:0] bit_idx,
   input wire logic       bit_val,
   input wire logic       rmw_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic [7:0] pin_in0,
   input wire logic [7:0] pin_in1,
   input wire logic [7:0] pin_out0,
   input wire logic [2:0] port_drive_select,
   input wire logic       mismatch_irq,
   input wire logic       mismatch_wake
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_reset_values: assert property (disable iff (1'h0) !resetn |=>
      port_drive_select == 3'h7 && pin_out0 == 8'hff) else $error("reset");
   a_drive_write: assert property (sfr_wr && sfr_addr == 8'hf6 |=> ##1
      {5'h00, port_drive_select} == ($past(sfr_wdata, 2) & 8'h07))
      else $error("drive select");
   a_latch_write: assert property (sfr_wr && sfr_addr == 8'h80 |=> ##1
      pin_out0 == $past(sfr_wdata, 2)) else $error("latch write");
   a_bit_write: assert property (bit_wr && !sfr_wr && sfr_addr == 8'h80
      |=> ##1 pin_out0[$past(bit_idx, 2)] == $past(bit_val, 2))
      else $error("bit write");
   a_pin_read: assert property (sfr_rd && sfr_addr == 8'h80 &&
      $past(resetn) && $past(resetn, 2) &&
      $stable(pin_in0) && pin_in0 == $past(pin_in0, 2) |=>
      sfr_rdata == $past(pin_in0)) else $error("pin read");
   a_rmw_read: assert property (rmw_rd && sfr_addr == 8'h80 |=>
      sfr_rdata == pin_out0) else $error("latch read");
   a_irq_wake: assert property (mismatch_irq == mismatch_wake)
      else $error("wake differs");
   a_mismatch_cause: assert property ($changed(mismatch_irq) &&
      $past(resetn) |-> $past(sfr_wr, 2) || $past(pin_in0, 3) !=
      $past(pin_in0, 4) || $past(pin_in1, 3) != $past(pin_in1, 4))
      else $error("mismatch change");
endmodule // gpio_port_asserts
bind gpio_port gpio_port_asserts i_gpio_port_asserts (.*);

// *** verification/pin_source.sv ***
/* pin_source: external circuitry on ports zero and one.
   assumes: the bench sets the levels; pins follow them between edges. */
`timescale 1ns/1ns
module pin_source (
   input  wire logic [7:0] lvl0,
   input  wire logic [7:0] lvl1,
   output wire logic [7:0] pin_in0,
   output wire logic [7:0] pin_in1
);
   // delay keeps pin edges away from the clock edge
   assign #1 pin_in0 = lvl0;
   assign #1 pin_in1 = lvl1;
endmodule // pin_source

// *** verification/tb_top.sv ***
/* tb_top: random and corner tests of the port block.
   assumes: gpio_port with port one built seven pins wide. */
`timescale 1ns/1ns
module tb_top;
   localparam int P1W = 7;
   logic       clk = 1'h0, resetn = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0;
   logic       bit_wr = 1'h0, bit_val = 1'h0, rmw_rd = 1'h0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, pin_in2 = 8'h00;
   logic [7:0] lvl0 = 8'h00, lvl1 = 8'h00, latch0, latch2, d, e, m, e0, m0;
   logic [2:0] bit_idx = 3'h0;
   wire  [7:0] sfr_rdata, pin_in0, pin_in1, pin_out0, pin_out1, pin_out2;
   wire  [2:0] port_drive_select;
   wire        mismatch_irq, mismatch_wake;
   int         n_fail = 0, n_tests = 0, cyc = 0, seed = 7;
   gpio_port #(.P1_WIDTH(P1W)) i_gpio_port (.*);
   pin_source i_pin_source (.*);
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail++;
         give_verdict;
      end
   end
   task give_verdict;
      if (n_fail == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // k: 0 byte write, 1 bit write, 2 latch read, 3 pin read
   task acc(input int k, input logic [7:0] a, dat);
      @(posedge clk);
      #1;
      sfr_addr = a;
      sfr_wdata = dat;
      {bit_val, bit_idx} = dat[3:0];
      {sfr_rd, rmw_rd, bit_wr, sfr_wr} = 4'h1 << k;
      @(posedge clk);
      #1;
      {sfr_rd, rmw_rd, bit_wr, sfr_wr} = 4'h0;
   endtask
   function logic mm(input logic [7:0] x1, k1, x0, k0);
      return (|((lvl1 ^ x1) & k1 & (8'hff >> (8 - P1W)))) ||
             (|((lvl0 ^ x0) & k0));
   endfunction
   initial begin
      repeat (16) @(posedge clk);
      #1 resetn = 1'h1;
      chk("drive", port_drive_select, 8'h07);
      chk("latch", pin_out0, 8'hff);
      acc(3, 8'hed, 8'h00);
      chk("expected", sfr_rdata, 8'hff);
      for (int i = 0; i < 40; i++) begin
         d = $random(seed);
         lvl0 = $random(seed);
         lvl1 = $random(seed);
         pin_in2 = $random(seed);
         acc(0, 8'h80, d);
         latch0 = d;
         acc(1, 8'h80, d ^ 8'h08);
         latch0[d[2:0]] = ~d[3];
         acc(0, 8'h90, ~d);
         acc(0, 8'ha0, d ^ 8'h5a);
         acc(1, 8'ha0, ~d);
         latch2 = d ^ 8'h5a;
         latch2[~d[2:0]] = ~d[3];
         @(posedge clk);
         #1 chk("port out", pin_out0, latch0);
         chk("port out", pin_out1, ~d);
         chk("port out", pin_out2, latch2);
         acc(2, 8'h80, 8'h00);
         chk("latch read", sfr_rdata, latch0);
         acc(2, 8'ha0, 8'h00);
         chk("latch read", sfr_rdata, latch2);
         acc(3, 8'h80, 8'h00);
         chk("pin read", sfr_rdata, lvl0);
         acc(3, 8'h90, 8'h00);
         chk("pin read", sfr_rdata, lvl1);
         acc(3, 8'ha0, 8'h00);
         chk("pin read", sfr_rdata, pin_in2);
         acc(0, 8'hf6, d);
         @(posedge clk);
         #1 chk("drive", port_drive_select, d[2:0]);
         e = $random(seed);
         m = (i < 4) ? 8'h80 : $random(seed);
         e0 = $random(seed);
         m0 = (i < 8) ? 8'h00 : $random(seed);
         if (i[0]) begin
            e = lvl1;
            e0 = lvl0;
         end
         acc(0, 8'hed, e);
         acc(0, 8'hee, m);
         acc(0, 8'hfc, e0);
         acc(0, 8'hfd, m0);
         acc(3, 8'hed, 8'h00);
         chk("expected", sfr_rdata, e);
         acc(3, 8'hfc, 8'h00);
         chk("expected", sfr_rdata, e0);
         repeat (3) @(posedge clk);
         #1;
         chk("mismatch", mismatch_irq, mm(e, m, e0, m0));
         chk("wake", mismatch_wake, mm(e, m, e0, m0));
      end
      acc(3, 8'h81, 8'h00);
      chk("unmapped", sfr_rdata, 8'h00);
      give_verdict;
   end
endmodule // tb_top
